// ===== hw/eipu_pkg.sv
/*
 * Package for the external interrupt priority unit: register indices,
 * bit positions, reset values and the source numbering.
 * Assumes an APB slave where the byte address is four times the index.
 */
package eipu_pkg;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int NUM_SRC = 11;
    localparam int NUM_PER = 5;

    // Register indices; byte address is index times four
    localparam logic [IDX_W-1:0] IDX_EXT01_CONTROL = 10'h088;
    localparam logic [IDX_W-1:0] IDX_FIRST_ENABLE = 10'h0A8;
    localparam logic [IDX_W-1:0] IDX_PRIORITY_LOW = 10'h0A9;
    localparam logic [IDX_W-1:0] IDX_SECOND_ENABLE = 10'h0B8;
    localparam logic [IDX_W-1:0] IDX_PRIORITY_HIGH = 10'h0B9;
    localparam logic [IDX_W-1:0] IDX_REQUEST_FLAGS = 10'h0C0;
    localparam logic [IDX_W-1:0] IDX_EDGE_POLARITY = 10'h0C8;
    localparam logic [IDX_W-1:0] IDX_SOURCE_FLAGS = 10'h0D0;
    localparam logic [IDX_W-1:0] IDX_SOURCE_MASK = 10'h0D1;
    localparam logic [IDX_W-1:0] IDX_UIO_ROUTE = 10'h0D2;
    localparam logic [IDX_W-1:0] IDX_UIO_POLARITY = 10'h0D3;
    localparam logic [IDX_W-1:0] IDX_SERVICE_STATUS = 10'h0D4;

    // Bit positions
    localparam int BIT_GLOBAL_ALLOW = 7;
    localparam int BIT_EXT0_ALLOW = 0;
    localparam int BIT_EXT1_ALLOW = 2;
    localparam int BIT_EXT0_TYPE = 0;
    localparam int BIT_EXT0_PEND = 1;
    localparam int BIT_EXT1_TYPE = 2;
    localparam int BIT_EXT1_PEND = 3;
    localparam int BIT_EXT3_RISING = 6;
    localparam int BIT_EXT2_RISING = 5;

    // Reset values
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_PRIORITY = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_UIO = 8'h00;

    // Source numbers, in polling order
    localparam logic [3:0] SRC_EXT0 = 4'h0;
    localparam logic [3:0] SRC_SER1 = 4'h1;
    localparam logic [3:0] SRC_TMR0 = 4'h2;
    localparam logic [3:0] SRC_EXT2 = 4'h3;
    localparam logic [3:0] SRC_EXT1 = 4'h4;
    localparam logic [3:0] SRC_EXT3 = 4'h5;
    localparam logic [3:0] SRC_TMR1 = 4'h6;
    localparam logic [3:0] SRC_EXT4 = 4'h7;
    localparam logic [3:0] SRC_SER0 = 4'h8;
    localparam logic [3:0] SRC_EXT5 = 4'h9;
    localparam logic [3:0] SRC_EXT6 = 4'hA;
endpackage

// ===== hw/eipu_top.sv
/*
 * External interrupt priority unit: pin and peripheral request capture,
 * request flags, enables, four-level priority with in-service tracking.
 * Assumes one clock, an APB master, and a core that pulses irq_ack and
 * irq_return for one cycle each.
 */
// What this block does
// - Edge control bit 6 selects ext3 edge: 0 falling, 1 rising.
// - Edge control bit 5 selects ext2 edge: 0 falling, 1 rising.
// - Request flags register holds ext6..ext2 pending in bits 5..1.
// - Multi-source lines OR masked per-source flags kept outside core registers.
// - Eight user I/O pins drive ext0 (high) and ext1 (low) with polarity.
// - Ext2 and ext3 come from dedicated pins with programmable edge.
// - Sources of ext4, ext5, ext6 become rising edges for the core.
// - Interrupt taken only when enabled; flag recorded regardless.
// - Flags set on request and cleared when the core enters service, except level-mode ext0/ext1 flags, which follow the line.
// - Smart card to ext4, keypad to ext5, bus/fault/comparator to ext6.
// - Reading the per-source flag register clears the flags read.
// - An ext0 request can wake the stopped processor.
// - Six priority groups pair sources as listed; ext6 stands alone in the sixth.
// - Group x priority from bit x of both priority registers.
// - High register bit is the upper bit of a four-level code.
// - Equal-level simultaneous requests resolved by fixed polling order.
// - Bit 6 of the low priority register has no priority effect.
// - Global allow bit 7 of first enable register blocks all core requests when 0; wake is not blocked.
// - Ext0/ext1 type bit: 1 edge, 0 level; falling edge and low level when the user pin polarity bit is 0.
// - Only a strictly higher level preempts a running service.
`timescale 1ns/1ps
`default_nettype none
module eipu_top #(
    parameter int NUM_UIO = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [eipu_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_UIO-1:0] user_io_pins,
    input wire logic dedicated_irq_pin_a,
    input wire logic dedicated_irq_pin_b,
    input wire logic smart_card_event,
    input wire logic keypad_event,
    input wire logic serial_bus_event,
    input wire logic supply_fault_event,
    input wire logic comparator_event,
    input wire logic core_timer0_req,
    input wire logic core_timer1_req,
    input wire logic core_serial0_req,
    input wire logic core_serial1_req,
    input wire logic irq_ack,
    input wire logic irq_return,
    output logic irq_request,
    output logic [3:0] irq_source,
    output logic [1:0] irq_level,
    output logic wake_request
);
    import eipu_pkg::*;

    localparam int NPIN = NUM_UIO + 2;

    logic [7:0] first_enable_register, second_enable_register, priority_low_bits;
    logic [7:0] priority_high_bits, edge_polarity_control, wbyte, read_value;
    logic ext0_trigger_type, ext1_trigger_type, ext0_pending, ext1_pending;
    logic wake_capable_irq_prev, int1_prev, wake_capable_irq_line, int1_line, ext2_event, ext3_event;
    logic access, wr, rd, global_allow, best_found, busy, eligible, take, mapped;
    logic [6:2] ext_pending_hi, hi_set, hi_clr;
    logic [6:4] line_prev, line_now;
    logic [NUM_PER-1:0] source_flags, source_mask, per_prev, per_now, per_rise;
    logic [NUM_UIO-1:0] uio_route, uio_polarity, uio_now;
    logic [NPIN-1:0] sync1, sync2, sync3, pin_filt, pin_prev;
    logic [3:0] in_service, best_idx;
    logic [1:0] best_lvl, cur_lvl;
    logic [IDX_W-1:0] idx;
    logic [NUM_SRC-1:0] req;

    // Level of a source from its group; only bits 5..0 are looked at
    function automatic logic [1:0] src_level(input logic [3:0] src);
        logic [2:0] grp;
        grp = src[3:1];
        src_level = {priority_high_bits[grp], priority_low_bits[grp]};
    endfunction

    function automatic logic is_reg(input logic [IDX_W-1:0] a, input logic [IDX_W-1:0] r);
        is_reg = (a == r);
    endfunction

    assign idx = paddr[ADDR_W-1:2];
    assign access = psel & penable & pready;
    assign wr = access & pwrite;
    assign rd = access & ~pwrite;
    assign wbyte = pwdata[7:0];
    assign global_allow = first_enable_register[BIT_GLOBAL_ALLOW];

    // Pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pin_filt <= '0;
            pin_prev <= '0;
        end else begin
            sync1 <= {dedicated_irq_pin_b, dedicated_irq_pin_a, user_io_pins};
            sync2 <= sync1;
            sync3 <= sync2;
            pin_filt <= (pin_filt & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
            pin_prev <= pin_filt;
        end
    end

    // User pins: polarity bit 1 means the pin is active high
    assign uio_now = ~(pin_filt[NUM_UIO-1:0] ^ uio_polarity);
    assign wake_capable_irq_line = |(uio_now & uio_route);
    assign int1_line = |(uio_now & ~uio_route);

    // Dedicated pins with selectable transition
    assign ext2_event = edge_polarity_control[BIT_EXT2_RISING] ?
        (pin_filt[NUM_UIO] & ~pin_prev[NUM_UIO]) :
        (~pin_filt[NUM_UIO] & pin_prev[NUM_UIO]);
    assign ext3_event = edge_polarity_control[BIT_EXT3_RISING] ?
        (pin_filt[NUM_UIO+1] & ~pin_prev[NUM_UIO+1]) :
        (~pin_filt[NUM_UIO+1] & pin_prev[NUM_UIO+1]);

    // Peripheral sources, same clock domain
    assign per_now = {comparator_event, supply_fault_event, serial_bus_event,
                      keypad_event, smart_card_event};
    assign per_rise = per_now & ~per_prev;
    assign line_now[4] = source_flags[0];
    assign line_now[5] = source_flags[1];
    assign line_now[6] = |source_flags[4:2];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            per_prev <= '0;
            line_prev <= '0;
            wake_capable_irq_prev <= 1'b0;
            int1_prev <= 1'b0;
        end else begin
            per_prev <= per_now;
            line_prev <= line_now;
            wake_capable_irq_prev <= wake_capable_irq_line;
            int1_prev <= int1_line;
        end
    end

    // Per-source flags; only the bits handed out on a read are cleared,
    // so an event landing between the data capture and the clear survives
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            source_flags <= RST_FLAGS[NUM_PER-1:0];
        end else if (rd && is_reg(idx, IDX_SOURCE_FLAGS)) begin
            source_flags <= (per_rise & source_mask) | (source_flags & ~prdata[NUM_PER-1:0]);
        end else begin
            source_flags <= (per_rise & source_mask) | source_flags;
        end
    end

    // Acknowledged source clears its own flag
    assign take = irq_ack & irq_request;

    assign hi_set[2] = ext2_event;
    assign hi_set[3] = ext3_event;
    assign hi_set[6:4] = line_now & ~line_prev;
    assign hi_clr[2] = take && irq_source == SRC_EXT2;
    assign hi_clr[3] = take && irq_source == SRC_EXT3;
    assign hi_clr[4] = take && irq_source == SRC_EXT4;
    assign hi_clr[5] = take && irq_source == SRC_EXT5;
    assign hi_clr[6] = take && irq_source == SRC_EXT6;

    // Request flags: a hardware set wins over a clear or a write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_pending_hi <= RST_FLAGS[6:2];
        end else if (wr && is_reg(idx, IDX_REQUEST_FLAGS)) begin
            ext_pending_hi <= hi_set | wbyte[5:1];
        end else begin
            ext_pending_hi <= hi_set | (ext_pending_hi & ~hi_clr);
        end
    end

    // Ext0/ext1: edge mode sets on assertion, level mode follows the line
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext0_pending <= 1'b0;
            ext1_pending <= 1'b0;
        end else begin
            if (!ext0_trigger_type) begin
                ext0_pending <= wake_capable_irq_line;
            end else if (wake_capable_irq_line && !wake_capable_irq_prev) begin
                ext0_pending <= 1'b1;
            end else if (wr && is_reg(idx, IDX_EXT01_CONTROL)) begin
                ext0_pending <= wbyte[BIT_EXT0_PEND];
            end else if (take && irq_source == SRC_EXT0) begin
                ext0_pending <= 1'b0;
            end
            if (!ext1_trigger_type) begin
                ext1_pending <= int1_line;
            end else if (int1_line && !int1_prev) begin
                ext1_pending <= 1'b1;
            end else if (wr && is_reg(idx, IDX_EXT01_CONTROL)) begin
                ext1_pending <= wbyte[BIT_EXT1_PEND];
            end else if (take && irq_source == SRC_EXT1) begin
                ext1_pending <= 1'b0;
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            first_enable_register <= RST_ENABLE;
            second_enable_register <= RST_ENABLE;
            priority_low_bits <= RST_PRIORITY;
            priority_high_bits <= RST_PRIORITY;
            edge_polarity_control <= RST_CONTROL;
            ext0_trigger_type <= 1'b0;
            ext1_trigger_type <= 1'b0;
            source_mask <= RST_UIO[NUM_PER-1:0];
            uio_route <= '0;
            uio_polarity <= '0;
        end else if (wr) begin
            if (is_reg(idx, IDX_FIRST_ENABLE)) begin
                first_enable_register <= wbyte;
            end
            if (is_reg(idx, IDX_SECOND_ENABLE)) begin
                second_enable_register <= wbyte;
            end
            if (is_reg(idx, IDX_PRIORITY_LOW)) begin
                priority_low_bits <= wbyte;
            end
            if (is_reg(idx, IDX_PRIORITY_HIGH)) begin
                priority_high_bits <= wbyte;
            end
            if (is_reg(idx, IDX_EDGE_POLARITY)) begin
                edge_polarity_control <= wbyte & 8'h60;
            end
            if (is_reg(idx, IDX_EXT01_CONTROL)) begin
                ext0_trigger_type <= wbyte[BIT_EXT0_TYPE];
                ext1_trigger_type <= wbyte[BIT_EXT1_TYPE];
            end
            if (is_reg(idx, IDX_SOURCE_MASK)) begin
                source_mask <= wbyte[NUM_PER-1:0];
            end
            if (is_reg(idx, IDX_UIO_ROUTE)) begin
                uio_route <= pwdata[NUM_UIO-1:0];
            end
            if (is_reg(idx, IDX_UIO_POLARITY)) begin
                uio_polarity <= pwdata[NUM_UIO-1:0];
            end
        end
    end

    // Enabled requests; core-side sources are enabled inside the core
    always_comb begin
        req = '0;
        req[SRC_EXT0] = ext0_pending & first_enable_register[BIT_EXT0_ALLOW];
        req[SRC_EXT1] = ext1_pending & first_enable_register[BIT_EXT1_ALLOW];
        req[SRC_EXT2] = ext_pending_hi[2] & second_enable_register[1];
        req[SRC_EXT3] = ext_pending_hi[3] & second_enable_register[2];
        req[SRC_EXT4] = ext_pending_hi[4] & second_enable_register[3];
        req[SRC_EXT5] = ext_pending_hi[5] & second_enable_register[4];
        req[SRC_EXT6] = ext_pending_hi[6] & second_enable_register[5];
        req[SRC_TMR0] = core_timer0_req;
        req[SRC_TMR1] = core_timer1_req;
        req[SRC_SER0] = core_serial0_req;
        req[SRC_SER1] = core_serial1_req;
        req = req & {NUM_SRC{global_allow}};
    end

    // Highest level wins; strict compare keeps the earlier polled source
    always_comb begin
        best_found = 1'b0;
        best_idx = 4'h0;
        best_lvl = 2'b00;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (req[i] && (!best_found || src_level(4'(i)) > best_lvl)) begin
                best_found = 1'b1;
                best_idx = 4'(i);
                best_lvl = src_level(4'(i));
            end
        end
    end

    assign busy = |in_service;
    assign cur_lvl = in_service[3] ? 2'd3 : in_service[2] ? 2'd2 :
                     in_service[1] ? 2'd1 : 2'd0;
    assign eligible = best_found && (!busy || best_lvl > cur_lvl);

    // Request to the core; dropped on the ack cycle so stale state never repeats
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_request <= 1'b0;
            irq_source <= 4'h0;
            irq_level <= 2'b00;
        end else begin
            irq_request <= eligible & ~take;
            irq_source <= best_idx;
            irq_level <= best_lvl;
        end
    end

    // In-service levels: return retires the highest, ack marks a new one
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            in_service <= 4'h0;
        end else begin
            in_service <= (in_service & ~((irq_return && busy) ? (4'h1 << cur_lvl) : 4'h0))
                          | (take ? (4'h1 << irq_level) : 4'h0);
        end
    end

    // Wake works with the core stopped, so no global allow here
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= ext0_pending & first_enable_register[BIT_EXT0_ALLOW];
        end
    end

    // Read mux
    always_comb begin
        read_value = 8'h00;
        mapped = 1'b1;
        case (idx)
            IDX_FIRST_ENABLE: read_value = first_enable_register;
            IDX_SECOND_ENABLE: read_value = second_enable_register;
            IDX_PRIORITY_LOW: read_value = priority_low_bits;
            IDX_PRIORITY_HIGH: read_value = priority_high_bits;
            IDX_EDGE_POLARITY: read_value = edge_polarity_control;
            IDX_REQUEST_FLAGS: read_value = {2'b00, ext_pending_hi, 1'b0};
            IDX_EXT01_CONTROL: read_value = {4'h0, ext1_pending, ext1_trigger_type,
                                             ext0_pending, ext0_trigger_type};
            IDX_SOURCE_FLAGS: read_value = 8'(source_flags);
            IDX_SOURCE_MASK: read_value = 8'(source_mask);
            IDX_UIO_ROUTE: read_value = 8'(uio_route);
            IDX_UIO_POLARITY: read_value = 8'(uio_polarity);
            IDX_SERVICE_STATUS: read_value = {in_service, 4'h0};
            default: mapped = 1'b0;
        endcase
    end

    // APB answer one cycle into the access phase, data held from a flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel && penable && !pready) begin
                prdata <= {24'h000000, read_value};
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/eipu_core_model.sv
/*
 * Behavioural core side: acknowledges the winning request, serves it,
 * then returns. Assumes the unit's clock and reset.
 */
`timescale 1ns/1ps
`default_nettype none
module eipu_core_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic [3:0] lat,
    input wire logic irq_request,
    input wire logic [3:0] irq_source,
    output logic irq_ack,
    output logic irq_return,
    output logic [3:0] last_src,
    output logic [7:0] served
);
    logic busy;
    logic [3:0] cnt;
    // One service at a time; no nesting, a simpler core than real
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            last_src <= 4'h0;
            served <= 8'h00;
            busy <= 1'b0;
            cnt <= 4'h0;
        end else begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            if (busy) begin
                cnt <= cnt + 4'h1;
                if (cnt == 4'hF) begin
                    irq_return <= 1'b1;
                    busy <= 1'b0;
                end
            end else if (run && irq_request && !irq_ack) begin
                cnt <= cnt + 4'h1;
                if (cnt >= lat) begin
                    irq_ack <= 1'b1;
                    busy <= 1'b1;
                    cnt <= 4'h0;
                    last_src <= irq_source;
                    served <= served + 8'h01;
                end
            end else begin
                cnt <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/eipu_top_asserts.sv
/*
 * Port checker for the interrupt priority unit.
 * Assumes one clock and the async active-low reset nrst.
 */
`timescale 1ns/1ps
`default_nettype none
module eipu_top_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq_ack,
    input wire logic irq_return,
    input wire logic irq_request,
    input wire logic [3:0] irq_source,
    input wire logic [1:0] irq_level,
    input wire logic wake_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic svc_on;
    logic [1:0] svc_lvl;
    // One-deep record; a nested return just ends the check
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            svc_on <= 1'b0;
            svc_lvl <= 2'h0;
        end else if (irq_ack && irq_request) begin
            svc_on <= 1'b1;
            svc_lvl <= irq_level;
        end else if (irq_return) begin
            svc_on <= 1'b0;
        end
    end
    a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_unmapped_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read data not zero");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_ack_drop: assert property (irq_ack && irq_request |=> !irq_request)
        else $error("request stands after acknowledge");
    a_src_range: assert property (irq_request |-> irq_source <= 4'hA)
        else $error("source number out of range");
    a_preempt_higher: assert property (irq_request && svc_on |-> irq_level > svc_lvl)
        else $error("request not above level in service");
    a_reset_quiet: assert property ($rose(nrst) |-> !irq_request && !wake_request)
        else $error("outputs active after reset");
endmodule
bind eipu_top eipu_top_asserts i_chk (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_ack(irq_ack),
    .irq_return(irq_return), .irq_request(irq_request), .irq_source(irq_source),
    .irq_level(irq_level), .wake_request(wake_request)
);
`default_nettype wire

// ===== bench/tb.sv
/*
 * Self-checking bench for the interrupt priority unit.
 * Assumes the core model and the bound port checker.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import eipu_pkg::*;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq_ack, irq_return;
    logic irq_request, wake_request, run, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] uio, served, q;
    logic [1:0] pins, irq_level;
    logic [4:0] ev;
    logic [3:0] creq, irq_source, lat, last_src;
    int err_count = 0, num_checks = 0;
    eipu_top i_eipu_top (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .user_io_pins(uio),
        .dedicated_irq_pin_a(pins[0]), .dedicated_irq_pin_b(pins[1]),
        .smart_card_event(ev[0]), .keypad_event(ev[1]), .serial_bus_event(ev[2]),
        .supply_fault_event(ev[3]), .comparator_event(ev[4]),
        .core_timer0_req(creq[0]), .core_timer1_req(creq[1]),
        .core_serial0_req(creq[2]), .core_serial1_req(creq[3]), .irq_ack(irq_ack),
        .irq_return(irq_return), .irq_request(irq_request), .irq_source(irq_source),
        .irq_level(irq_level), .wake_request(wake_request));
    eipu_core_model i_eipu_core_model (.clk(clk), .nrst(nrst), .run(run), .lat(lat),
        .irq_request(irq_request), .irq_source(irq_source), .irq_ack(irq_ack),
        .irq_return(irq_return), .last_src(last_src), .served(served));
    always #2 clk = ~clk;
    task automatic test_done;
        $display("Checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    // Request held until pready is seen; no latency assumed
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
        output logic [7:0] q, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_count++;
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, q, e);
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00, q, e);
        chk({e, q}, {1'b0, exp});
    endtask
    function automatic logic [5:0] win(input logic [3:0] r, input logic [7:0] p0, p1);
        logic [3:0] src [4];
        int grp [4];
        logic [1:0] bl, l;
        logic [3:0] bs;
        src = '{SRC_TMR0, SRC_TMR1, SRC_SER0, SRC_SER1};
        grp = '{1, 3, 4, 0};
        bl = 2'h0;
        bs = 4'hF;
        for (int i = 0; i < 4; i++) begin
            l = {p1[grp[i]], p0[grp[i]]};
            if (r[i] && (bs == 4'hF || l > bl || (l == bl && src[i] < bs))) begin
                bl = l;
                bs = src[i];
            end
        end
        return {bl, bs};
    endfunction
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        test_done();
    end
    initial begin
        logic [7:0] p0, p1;
        logic [3:0] r;
        int n;
        {clk, nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        {uio, pins, ev, creq, run, lat} = '0;
        void'($urandom(32'hC53E));
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rdc(IDX_PRIORITY_LOW, RST_PRIORITY);
        rdc(IDX_PRIORITY_HIGH, RST_PRIORITY);
        rdc(IDX_REQUEST_FLAGS, RST_FLAGS);
        rdc(IDX_EDGE_POLARITY, RST_CONTROL);
        apb(1'b0, 10'h3FF, 8'h00, q, e);
        chk({e, q}, 9'h100);
        for (int k = 0; k < 4; k++) begin
            p0 = 8'($urandom);
            wr(IDX_EDGE_POLARITY, p0);
            rdc(IDX_EDGE_POLARITY, p0 & 8'h60);
        end
        // Dedicated pins, both edge selections; all enables off
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 2; s++) begin
                wr(IDX_EDGE_POLARITY, 8'(s) << (5 + p));
                pins[p] <= 1'(!s);
                repeat (10) @(posedge clk);
                wr(IDX_REQUEST_FLAGS, 8'h00);
                pins[p] <= 1'(s);
                repeat (10) @(posedge clk);
                rdc(IDX_REQUEST_FLAGS, 8'h02 << p);
                wr(IDX_REQUEST_FLAGS, 8'h00);
                pins[p] <= 1'(!s);
                repeat (10) @(posedge clk);
                rdc(IDX_REQUEST_FLAGS, 8'h00);
            end
        end
        wr(IDX_SOURCE_MASK, 8'h1F);
        for (int i = 0; i < 5; i++) begin
            wr(IDX_REQUEST_FLAGS, 8'h00);
            ev[i] <= 1'b1;
            repeat (4) @(posedge clk);
            rdc(IDX_REQUEST_FLAGS, (i < 2) ? (8'h08 << i) : 8'h20);
            rdc(IDX_SOURCE_FLAGS, 8'h01 << i);
            rdc(IDX_SOURCE_FLAGS, 8'h00);
            rdc(IDX_REQUEST_FLAGS, (i < 2) ? (8'h08 << i) : 8'h20);
            ev[i] <= 1'b0;
        end
        wr(IDX_REQUEST_FLAGS, 8'h00);
        for (int k = 0; k < 12; k++) begin
            p0 = (k == 0) ? 8'h00 : 8'($urandom);
            p1 = (k == 0) ? 8'h00 : 8'($urandom);
            r = (k == 0) ? 4'hF : 4'($urandom);
            if (r == 4'h0) r = 4'h5;
            wr(IDX_PRIORITY_LOW, p0);
            wr(IDX_PRIORITY_HIGH, p1);
            creq <= r;
            repeat (4) @(posedge clk);
            chk(irq_request, 1'b0);
            wr(IDX_FIRST_ENABLE, 8'h80);
            repeat (4) @(posedge clk);
            chk({irq_request, irq_level, irq_source}, {1'b1, win(r, p0, p1)});
            apb(1'b0, IDX_PRIORITY_LOW, 8'h00, q, e);
            chk(q, p0);
            creq <= 4'h0;
            wr(IDX_FIRST_ENABLE, 8'h00);
        end
        // Service through the core model, slow acknowledge
        wr(IDX_EDGE_POLARITY, 8'h20);
        wr(IDX_SECOND_ENABLE, 8'h02);
        wr(IDX_FIRST_ENABLE, 8'h80);
        lat <= 4'($urandom_range(1, 6));
        run <= 1'b1;
        pins[0] <= 1'b1;
        n = 0;
        while (served == 8'h00 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk(last_src, SRC_EXT2);
        rdc(IDX_REQUEST_FLAGS, 8'h00);
        run <= 1'b0;
        creq <= 4'h1;
        repeat (3) @(posedge clk);
        chk(irq_request, 1'b0);
        wr(IDX_FIRST_ENABLE, 8'h01);
        wr(IDX_UIO_ROUTE, 8'h01);
        wr(IDX_UIO_POLARITY, 8'h01);
        wr(IDX_EXT01_CONTROL, 8'h01);
        uio <= 8'h01;
        repeat (10) @(posedge clk);
        chk(wake_request, 1'b1);
        apb(1'b0, IDX_EXT01_CONTROL, 8'h00, q, e);
        chk(q & 8'h03, 8'h03);
        wr(IDX_EXT01_CONTROL, 8'h00);
        uio <= 8'h00;
        repeat (10) @(posedge clk);
        chk(wake_request, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
